/* sync_sram_burst_port.sv */
// synchronous flow-through burst sram port with single-cycle turnaround
`timescale 1ns/1ps
`include "sram_port_consts.svh"
module sync_sram_burst_port
#(
    parameter int ADDR_WIDTH = `SRAM_ADDR_WIDTH,
    parameter int DATA_WIDTH = `SRAM_DATA_WIDTH,
    parameter int LANES = `SRAM_LANES
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic clock_gate_n_in,
    input wire logic chip_select_low_a_n_in,
    input wire logic chip_select_low_b_n_in,
    input wire logic chip_select_pair_second_in,
    input wire logic load_or_advance_in,
    input wire logic read_not_write_in,
    input wire logic [LANES-1:0] byte_lane_write_n_in,
    input wire logic burst_order_select_in,
    input wire logic output_gate_n_in,
    input wire logic [ADDR_WIDTH-1:0] addr_in,
    input wire logic [DATA_WIDTH-1:0] data_in,
    output logic [DATA_WIDTH-1:0] data_out,
    output logic data_oe_out
);
    import sram_port_pkg::*;

    localparam int BB = `SRAM_BURST_BITS;

    // pins pass two flops; the state logic therefore sees the pins two cycles late
    logic [7:0] ctl_a;
    logic [7:0] ctl_b;
    logic [LANES-1:0] lane_a;
    logic [LANES-1:0] lane_b;
    logic [ADDR_WIDTH-1:0] addr_a;
    logic [ADDR_WIDTH-1:0] addr_b;
    logic [DATA_WIDTH-1:0] din_a;
    logic [DATA_WIDTH-1:0] din_b;

    logic gate_n;
    logic cs_a_n;
    logic cs_b_n;
    logic cs_p;
    logic adv;
    logic rnw;
    logic order;
    logic oe_n;
    logic [LANES-1:0] lane_n;
    logic [ADDR_WIDTH-1:0] addr;

    // operation registers
    cycle_type op;
    cycle_type next_op;
    cycle_type burst_dir;
    cycle_type next_burst_dir;
    logic [ADDR_WIDTH-1:0] base;
    logic [ADDR_WIDTH-1:0] next_base;
    logic [BB-1:0] count;
    logic [BB-1:0] next_count;
    logic [ADDR_WIDTH-1:0] op_addr;
    logic [ADDR_WIDTH-1:0] next_op_addr;
    logic [LANES-1:0] op_lane_n;
    logic [LANES-1:0] next_op_lane_n;
    logic burst_order;
    logic next_burst_order;

    logic [DATA_WIDTH-1:0] rd_word;
    logic [DATA_WIDTH-1:0] next_data;
    logic next_oe;
    logic [LANES-1:0] wlane;
    logic selected;
    logic [BB-1:0] step_low;

    // low address bits of a burst word; upper bits never move inside a burst
    function automatic logic [BB-1:0] burst_low(input logic [BB-1:0] start, input logic [BB-1:0] step,
                                                input logic interleave);
        if (interleave) begin
            return start ^ step;
        end else begin
            return BB'(start + step);
        end
    endfunction

    // a gated edge still shifts the synchronisers; only the state below honours it
    always_ff @(posedge clk_in) begin
        ctl_a <= {clock_gate_n_in, chip_select_low_a_n_in, chip_select_low_b_n_in, chip_select_pair_second_in,
                  load_or_advance_in, read_not_write_in, burst_order_select_in, output_gate_n_in};
        ctl_b <= ctl_a;
        lane_a <= byte_lane_write_n_in;
        lane_b <= lane_a;
        addr_a <= addr_in;
        addr_b <= addr_a;
        din_a <= data_in;
        din_b <= din_a;
    end

    assign gate_n = ctl_b[7];
    assign cs_a_n = ctl_b[6];
    assign cs_b_n = ctl_b[5];
    assign cs_p = ctl_b[4];
    assign adv = ctl_b[3];
    assign rnw = ctl_b[2];
    assign order = ctl_b[1];
    assign oe_n = ctl_b[0];
    assign lane_n = lane_b;
    assign addr = addr_b;
    assign selected = !cs_a_n && !cs_b_n && cs_p;

    // write lanes act while a write data cycle is live and the edge is not gated
    always_comb begin
        if (op == cyc_write && !gate_n) begin
            wlane = ~op_lane_n;
        end else begin
            wlane = '0;
        end
    end

    // flow-through array: the read word is registered once, at the output

    sram_port_array #(
        .ADDR_WIDTH(ADDR_WIDTH),
        .LANES(LANES),
        .LANE_WIDTH(DATA_WIDTH / LANES)
    ) u_array (
        .clk_in(clk_in),
        .waddr_in(op_addr),
        .wlane_in(wlane),
        .wdata_in(din_b),
        .raddr_in(op_addr),
        .rdata_out(rd_word)
    );

    always_comb begin
        next_op = op;
        next_burst_dir = burst_dir;
        next_base = base;
        next_count = count;
        next_op_addr = op_addr;
        next_op_lane_n = op_lane_n;
        next_burst_order = burst_order;
        step_low = count + 2'(1);
        if (!gate_n) begin
            if (!adv) begin
                next_op_lane_n = lane_n;
                if (selected) begin
                    // load: a pending word in flight still completes this edge
                    next_op = rnw ? cyc_read : cyc_write;
                    next_burst_dir = next_op;
                    next_base = addr;
                    next_count = '0;
                    next_burst_order = order;
                    next_op_addr = addr;
                end else begin
                    next_op = cyc_idle;
                    next_burst_dir = cyc_idle;
                end
            end else begin
                // direction comes from the load, not from read_not_write
                next_op = burst_dir;
                next_op_lane_n = lane_n;
                next_count = step_low;
                next_op_addr = {base[ADDR_WIDTH-1:BB],
                                burst_low(base[BB-1:0], step_low, burst_order)};
            end
        end
    end

    // memory contents are left alone by reset; only control state clears
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            op <= cyc_idle;
            burst_dir <= cyc_idle;
            base <= '0;
            count <= '0;
            op_addr <= '0;
            op_lane_n <= '1;
            burst_order <= 1'b0;
        end else begin
            op <= next_op;
            burst_dir <= next_burst_dir;
            base <= next_base;
            count <= next_count;
            op_addr <= next_op_addr;
            op_lane_n <= next_op_lane_n;
            burst_order <= next_burst_order;
        end
    end

    // output gate touches only the drivers; registered so outputs come from flops
    always_comb begin
        next_data = rd_word;
        next_oe = 1'b0;
        if (op == cyc_read && !oe_n) begin
            next_oe = 1'b1;
        end
    end

    // oe clears on reset so the bus is never driven before a read
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            data_out <= '0;
            data_oe_out <= 1'b0;
        end else begin
            data_out <= next_data;
            data_oe_out <= next_oe;
        end
    end
endmodule

/* sram_port_consts.svh */
// constants for the synchronous burst sram port
`ifndef SRAM_PORT_CONSTS_SVH
`define SRAM_PORT_CONSTS_SVH
`define SRAM_ADDR_WIDTH 20
`define SRAM_DATA_WIDTH 18
`define SRAM_LANES 2
`define SRAM_BURST_BITS 2
`endif

/* sram_port_pkg.sv */
// types for the synchronous burst sram port
package sram_port_pkg;
    typedef enum logic [2:0] {
        cyc_idle = 3'b001,
        cyc_read = 3'b010,
        cyc_write = 3'b100
    } cycle_type;
endpackage

/* sram_port_array.sv */
// flip-flop storage array with per-lane write enables
`timescale 1ns/1ps
module sram_port_array #(
    parameter int ADDR_WIDTH = 4,
    parameter int LANES = 2,
    parameter int LANE_WIDTH = 9
) (
    input wire logic clk_in,
    input wire logic [ADDR_WIDTH-1:0] waddr_in,
    input wire logic [LANES-1:0] wlane_in,
    input wire logic [LANES*LANE_WIDTH-1:0] wdata_in,
    input wire logic [ADDR_WIDTH-1:0] raddr_in,
    output logic [LANES*LANE_WIDTH-1:0] rdata_out
);
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : lane
            // one array per lane so each array has a single writing process
            logic [LANE_WIDTH-1:0] mem [2**ADDR_WIDTH];

            // flow-through read: no output register
            assign rdata_out[g*LANE_WIDTH +: LANE_WIDTH] = mem[raddr_in];

            always_ff @(posedge clk_in) begin
                if (wlane_in[g]) begin
                    mem[waddr_in] <= wdata_in[g*LANE_WIDTH +: LANE_WIDTH];
                end
            end
        end
    endgenerate
endmodule

/* sram_port_monitor.sv */
// assertion checker for the burst sram port
`timescale 1ns/1ps
module sram_port_monitor (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic clock_gate_n_in,
    input wire logic chip_select_low_a_n_in,
    input wire logic chip_select_low_b_n_in,
    input wire logic chip_select_pair_second_in,
    input wire logic load_or_advance_in,
    input wire logic read_not_write_in,
    input wire logic output_gate_n_in,
    input wire logic data_oe_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    wire g = !clock_gate_n_in;
    wire sel = !chip_select_low_a_n_in && !chip_select_low_b_n_in && chip_select_pair_second_in;
    wire rd = g && sel && !load_or_advance_in && read_not_write_in;
    wire wl = g && sel && !load_or_advance_in && !read_not_write_in;
    wire ds = g && !sel && !load_or_advance_in;
    wire av = g && load_or_advance_in;
    wire on = g && !output_gate_n_in;
    wire off = g && output_gate_n_in;
    property p_rd; rd ##1 on ##1 g ##1 g |=> data_oe_out; endproperty
    a_rd: assert property (p_rd) else $error("read slot not driven");
    property p_bu; rd ##1 (av && on) ##1 on ##1 g ##1 g |=> data_oe_out; endproperty
    a_bu: assert property (p_bu) else $error("burst slot not driven");
    property p_wr; wl ##1 g ##1 g ##1 g |=> !data_oe_out; endproperty
    a_wr: assert property (p_wr) else $error("bus driven in write slot");
    property p_ta; wl ##1 rd ##1 on ##1 g ##1 g |=> $rose(data_oe_out); endproperty
    a_ta: assert property (p_ta) else $error("write to read turn failed");
    property p_ds; ds ##1 (ds || av) ##1 g[*3] |=> !data_oe_out; endproperty
    a_ds: assert property (p_ds) else $error("bus driven after deselect");
    property p_og; g ##1 off ##1 g ##1 g |=> !data_oe_out; endproperty
    a_og: assert property (p_og) else $error("gated output still driven");
    property p_sp; !g ##1 $stable(output_gate_n_in) |-> ##3 $stable(data_oe_out); endproperty
    a_sp: assert property (p_sp) else $error("suspended edge changed bus");
    property p_ig; wl ##1 (av && read_not_write_in) ##1 g[*3] |=> !data_oe_out; endproperty
    a_ig: assert property (p_ig) else $error("advance took new direction");
endmodule
bind sync_sram_burst_port sram_port_monitor i_mon (.*);

/* sram_ctrl_model.sv */
// controller model: selects, load or advance, direction, delayed write data
`timescale 1ns/1ps
module sram_ctrl_model (
    input wire logic clk_in,
    input wire logic [1:0] op_in,
    input wire logic [17:0] wdata_in,
    output logic [2:0] cs_out,
    output logic load_out,
    output logic rnw_out,
    output logic [17:0] data_out
);
    logic wr = 1'h0;
    wire w = op_in == 2'h2 || (op_in == 2'h3 && wr);
    assign cs_out = op_in == 2'h0 ? 3'h6 : 3'h1;
    assign load_out = op_in == 2'h3;
    // advance drives read on purpose, direction must come from the load
    assign rnw_out = op_in != 2'h2;
    initial data_out = 18'h0;
    always @(posedge clk_in) begin
        wr <= w;
        // released bus toggles so a stale word cannot pass
        data_out <= w ? wdata_in : ~data_out;
    end
endmodule

/* tb_top.sv */
// testbench for the burst sram port
`timescale 1ns/1ps
module tb_top;
    logic clk_in = 1'h0, rst_in = 1'h1, clock_gate_n_in = 1'h0, burst_order_select_in = 1'h0;
    logic output_gate_n_in = 1'h0, gt = 1'h0, bov = 1'h0, ogv = 1'h0;
    logic [1:0] op = 2'h0, byte_lane_write_n_in = 2'h0, lnv = 2'h0;
    logic [19:0] addr_in = 20'h0;
    logic [17:0] wd = 18'h0;
    wire chip_select_low_a_n_in, chip_select_low_b_n_in, chip_select_pair_second_in;
    wire load_or_advance_in, read_not_write_in, data_oe_out;
    wire [17:0] data_in, data_out;
    logic [18:0] eq[$];
    int bad_count = 0;
    int num_checks = 0;
    localparam logic [19:0] B = 20'hA5C40;
    initial forever #2 clk_in = ~clk_in;
    sram_ctrl_model i_ctl (.clk_in(clk_in), .op_in(op), .wdata_in(wd), .load_out(load_or_advance_in),
        .cs_out({chip_select_low_a_n_in, chip_select_low_b_n_in, chip_select_pair_second_in}),
        .rnw_out(read_not_write_in), .data_out(data_in));
    sync_sram_burst_port i_dut (.*);
    function automatic logic [17:0] w(input int i);
        return 18'h2A5C0 ^ 18'(i);
    endfunction
    task check(input logic [18:0] s, input logic [18:0] e);
        num_checks++;
        if (s !== e) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // e is the slot expected for this pin cycle, oe in the top bit
    task cyc(input logic [1:0] o, input logic [19:0] a, input logic [17:0] d, input logic [18:0] e);
        @(posedge clk_in);
        op <= o;
        addr_in <= a;
        wd <= d;
        clock_gate_n_in <= gt;
        output_gate_n_in <= ogv;
        burst_order_select_in <= bov;
        byte_lane_write_n_in <= lnv;
        eq.push_back(e);
    endtask
    always @(negedge clk_in)
        if (eq.size() == 5)
            check({data_oe_out, data_oe_out ? data_out : 18'h0}, eq.pop_front());
    // idle slots until every expected slot of the scenario has been judged
    task drain;
        repeat (5) cyc(2'h0, '0, '0, 19'h0);
    endtask
    task t_fill;
        for (int i = 0; i < 4; i++) cyc(2'h2, B + 20'(i), w(i), 19'h0);
        cyc(2'h1, B + 20'h3, '0, {1'h1, w(3)});
        drain;
    endtask
    task t_burst;
        cyc(2'h1, B + 20'h1, '0, {1'h1, w(1)});
        for (int i = 2; i < 5; i++) cyc(2'h3, '0, '0, {1'h1, w(i % 4)});
        bov = 1'h1;
        cyc(2'h1, B + 20'h1, '0, {1'h1, w(1)});
        cyc(2'h3, '0, '0, {1'h1, w(0)});
        bov = 1'h0;
        cyc(2'h1, B + 20'h3, '0, {1'h1, w(3)});
        cyc(2'h3, '0, '0, {1'h1, w(0)});
        cyc(2'h0, '0, '0, 19'h0);
        cyc(2'h3, '0, '0, 19'h0);
        drain;
    endtask
    task t_bwrite;
        bov = 1'h1;
        cyc(2'h2, B + 20'h2, w(8), 19'h0);
        for (int i = 9; i < 12; i++) cyc(2'h3, '0, w(i), 19'h0);
        for (int i = 0; i < 4; i++) cyc(2'h1, B + 20'(i), '0, {1'h1, w(8 + (i ^ 2))});
        drain;
    endtask
    task t_lane;
        lnv = 2'h2;
        cyc(2'h2, B, 18'h3FFFF, 19'h0);
        lnv = 2'h0;
        cyc(2'h1, B, '0, {1'h1, 18'h2A5FF});
        drain;
    endtask
    task t_gate;
        cyc(2'h1, B + 20'h1, '0, 19'h0);
        ogv = 1'h1;
        cyc(2'h0, '0, '0, 19'h0);
        ogv = 1'h0;
        cyc(2'h0, '0, '0, 19'h0);
        gt = 1'h1;
        cyc(2'h2, B + 20'h1, '0, 19'h0);
        gt = 1'h0;
        for (int i = 0; i < 3; i++) cyc(2'h0, '0, '0, 19'h0);
        cyc(2'h1, B + 20'h1, '0, {1'h1, w(11)});
        drain;
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk_in);
        rst_in <= 1'h0;
        t_fill;
        t_burst;
        t_bwrite;
        t_lane;
        t_gate;
        repeat (5) cyc(2'h0, '0, '0, 19'h0);
        summarize;
    end
    initial begin
        #4000;
        bad_count++;
        summarize;
    end
endmodule
